// ==== shared/rtca_pkg.sv ====
`default_nettype none
package rtca_pkg;
	// Register indices; the byte address is four times the index
	localparam logic [9:0]  RTCA_IDX_ALARM_SEC   = 10'h0e8;
	localparam logic [9:0]  RTCA_IDX_ALARM_MIN   = 10'h0e9;
	localparam logic [9:0]  RTCA_IDX_ALARM_HOUR  = 10'h0ea;
	localparam logic [9:0]  RTCA_IDX_ALARM_WDAY  = 10'h0eb;
	localparam logic [9:0]  RTCA_IDX_ALARM_EN    = 10'h0ec;
	localparam logic [9:0]  RTCA_IDX_CTRL        = 10'h0ed;
	localparam int unsigned RTCA_ADDR_W          = 12;

	// Control register bit positions
	localparam int unsigned RTCA_CTRL_ALARM      = 7;
	localparam int unsigned RTCA_CTRL_INT_EN     = 6;
	localparam int unsigned RTCA_CTRL_BCD        = 5;
	localparam int unsigned RTCA_CTRL_CLK_SEL    = 4;
	localparam int unsigned RTCA_CTRL_MAINS_FREQUENCY_SELECT   = 3;
	localparam int unsigned RTCA_CTRL_WAKE       = 1;
	localparam int unsigned RTCA_CTRL_UNLOCK     = 0;

	// Alarm enable bit positions
	localparam int unsigned RTCA_EN_WDAY         = 3;
	localparam int unsigned RTCA_EN_HOUR         = 2;
	localparam int unsigned RTCA_EN_MIN          = 1;
	localparam int unsigned RTCA_EN_SEC          = 0;

	// Reset values and masks
	localparam logic [3:0]  RTCA_EN_RESET        = 4'h0;
	localparam logic        RTCA_INT_EN_RESET    = 1'b0;
	localparam logic        RTCA_UNLOCK_RESET    = 1'b0;
	localparam logic        RTCA_ALARM_RESET     = 1'b0;
	localparam logic [15:0] RTCA_DIV_RESET       = 16'h0000;
	localparam logic [31:0] RTCA_RDATA_RESET     = 32'h0000_0000;

	// Prescale divisors
	localparam logic [15:0] RTCA_XTAL_DIV        = 16'h8000;
	localparam logic [15:0] RTCA_MAINS_60_DIV    = 16'h003c;
	localparam logic [15:0] RTCA_MAINS_50_DIV    = 16'h0032;

	typedef struct packed {
		logic [7:0] wday;
		logic [7:0] hour;
		logic [7:0] minute;
		logic [7:0] second;
	} rtca_time_t;

	// State that survives a reset
	typedef struct packed {
		rtca_time_t setpoint;
		logic       bcd;
		logic       clk_sel;
		logic       mains_frequency_select;
		logic       wake_cause;
	} rtca_ret_t;

	// State cleared by a reset
	typedef struct packed {
		logic [3:0]  match_en;
		logic        int_en;
		logic        unlock;
		logic        alarm;
		logic [15:0] div;
		logic [2:0]  xtal_sync;
		logic [2:0]  mains_sync;
		logic        tick;
		logic        wake_pulse;
		logic [31:0] rdata;
	} rtca_ctl_t;
endpackage
`default_nettype wire

// ==== logic/rtca_alarm_ctrl.sv ====
// Function
// - Alarm hours: BCD tens 0-2, or binary 00h-17h
// - Weekday register: upper nibble zero, value 1-7
// - Weekday writes accepted only while counter unlocked
// - Alarm hours always read/write, kept across reset
// - Four field enables bits 3:0, upper nibble zero
// - Reset clears all alarm field enables
// - Control bit 7 alarm flag; read clears it
// - Alarm reevaluated on count advance or relock
// - Any control write resets the prescale divider
// - Control bit 6 gates the alarm interrupt
// - Control bit 5 selects BCD or binary encoding
// - Bit 4 low: crystal enabled, divide by 32768
// - Bit 4 high: mains input, crystal disabled
// - Bit 3 selects 60 Hz or 50 Hz prescale
// - Bit 1 shows alarm caused sleep wake-up
// - Control read clears the sleep-wake cause
// - Bit 0 unlock: writes allowed, counting halted
// - Seconds/minutes set-points: tens 0-5, binary to 3Bh
//
// Local design decision: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module rtca_alarm_ctrl
	import rtca_pkg::*;
(
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [RTCA_ADDR_W-1:0] paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	input  wire logic                   xtal_in,
	input  wire logic                   mains_in,
	input  wire rtca_time_t             count_now,
	input  wire logic                   count_advanced,
	input  wire logic                   sleep_active,
	output logic                        osc_enable,
	output logic                        count_tick,
	output logic                        count_write_enable,
	output logic                        bcd_mode,
	output logic                        alarm_irq,
	output logic                        wake_request
);

	rtca_ret_t   ret_reg;
	rtca_ret_t   ret_next;
	rtca_ctl_t   ctl_reg;
	rtca_ctl_t   ctl_next;

	logic        setup_phase;
	logic        access_phase;
	logic        bus_wr;
	logic        bus_rd;
	logic [9:0]  word_idx;
	logic        hit_sec;
	logic        hit_min;
	logic        hit_hour;
	logic        hit_wday;
	logic        hit_en;
	logic        hit_ctrl;
	logic        mapped;
	logic        wr_ctrl;
	logic        rd_ctrl;
	logic        relock;
	logic        evaluate;
	logic [3:0]  field_eq;
	logic        match;
	logic        alarm_set;
	logic        xtal_edge;
	logic        mains_edge;
	logic        src_edge;
	logic [15:0] div_limit;
	logic        div_wrap;
	logic [7:0]  ctrl_view;
	logic [7:0]  read_byte;

	// Bus decode: zero wait states, error on unmapped words
	assign setup_phase  = psel & ~penable;
	assign access_phase = psel & penable;
	assign bus_wr       = access_phase & pwrite;
	assign bus_rd       = access_phase & ~pwrite;
	assign word_idx     = paddr[RTCA_ADDR_W-1:2];
	assign hit_sec      = (word_idx == RTCA_IDX_ALARM_SEC);
	assign hit_min      = (word_idx == RTCA_IDX_ALARM_MIN);
	assign hit_hour     = (word_idx == RTCA_IDX_ALARM_HOUR);
	assign hit_wday     = (word_idx == RTCA_IDX_ALARM_WDAY);
	assign hit_en       = (word_idx == RTCA_IDX_ALARM_EN);
	assign hit_ctrl     = (word_idx == RTCA_IDX_CTRL);
	assign mapped       = hit_sec | hit_min | hit_hour | hit_wday | hit_en | hit_ctrl;
	assign wr_ctrl      = bus_wr & hit_ctrl;
	assign rd_ctrl      = bus_rd & hit_ctrl;

	// Relock is a control write that drops the unlock bit
	assign relock   = wr_ctrl & ctl_reg.unlock & ~pwdata[RTCA_CTRL_UNLOCK];
	assign evaluate = count_advanced | relock;

	// Compare the stored pattern as written; both encodings compare bytewise
	assign field_eq[RTCA_EN_SEC]  = (ret_reg.setpoint.second == count_now.second);
	assign field_eq[RTCA_EN_MIN]  = (ret_reg.setpoint.minute == count_now.minute);
	assign field_eq[RTCA_EN_HOUR] = (ret_reg.setpoint.hour == count_now.hour);
	assign field_eq[RTCA_EN_WDAY] = (ret_reg.setpoint.wday == count_now.wday);
	assign match     = (|ctl_reg.match_en) & (&(field_eq | ~ctl_reg.match_en));
	assign alarm_set = evaluate & match;

	// Third sync stage only feeds the edge detectors
	assign xtal_edge  = ctl_reg.xtal_sync[1] & ~ctl_reg.xtal_sync[2];
	assign mains_edge = ctl_reg.mains_sync[1] & ~ctl_reg.mains_sync[2];
	assign src_edge   = ret_reg.clk_sel ? mains_edge : xtal_edge;
	assign div_limit  = !ret_reg.clk_sel ? RTCA_XTAL_DIV :
		(ret_reg.mains_frequency_select ? RTCA_MAINS_50_DIV : RTCA_MAINS_60_DIV);
	assign div_wrap   = (ctl_reg.div == div_limit - 16'h0001);

	always_comb begin
		ctrl_view                      = 8'h00;
		ctrl_view[RTCA_CTRL_ALARM]     = ctl_reg.alarm;
		ctrl_view[RTCA_CTRL_INT_EN]    = ctl_reg.int_en;
		ctrl_view[RTCA_CTRL_BCD]       = ret_reg.bcd;
		ctrl_view[RTCA_CTRL_CLK_SEL]   = ret_reg.clk_sel;
		ctrl_view[RTCA_CTRL_MAINS_FREQUENCY_SELECT]  = ret_reg.mains_frequency_select;
		ctrl_view[RTCA_CTRL_WAKE]      = ret_reg.wake_cause;
		ctrl_view[RTCA_CTRL_UNLOCK]    = ctl_reg.unlock;
	end

	always_comb begin
		read_byte = 8'h00;
		if (hit_sec)
			read_byte = ret_reg.setpoint.second;
		else if (hit_min)
			read_byte = ret_reg.setpoint.minute;
		else if (hit_hour)
			read_byte = ret_reg.setpoint.hour;
		else if (hit_wday)
			read_byte = {4'h0, ret_reg.setpoint.wday[3:0]};
		else if (hit_en)
			read_byte = {4'h0, ctl_reg.match_en};
		else if (hit_ctrl)
			read_byte = ctrl_view;
	end

	always_comb begin
		ret_next = ret_reg;
		ctl_next = ctl_reg;

		ctl_next.xtal_sync  = {ctl_reg.xtal_sync[1:0], xtal_in};
		ctl_next.mains_sync = {ctl_reg.mains_sync[1:0], mains_in};

		// Read data is caught in the setup phase so it is stable through access
		if (setup_phase && !pwrite)
			ctl_next.rdata = {24'h000000, read_byte};

		// Divider halts while unlocked so the count cannot move under software
		ctl_next.tick = 1'b0;
		if (wr_ctrl) begin
			ctl_next.div = RTCA_DIV_RESET;
		end else if (!ctl_reg.unlock && src_edge) begin
			ctl_next.tick = div_wrap;
			ctl_next.div  = div_wrap ? RTCA_DIV_RESET : ctl_reg.div + 16'h0001;
		end

		if (bus_wr) begin
			if (hit_sec)
				ret_next.setpoint.second = pwdata[7:0];
			if (hit_min)
				ret_next.setpoint.minute = pwdata[7:0];
			if (hit_hour)
				ret_next.setpoint.hour = pwdata[7:0];
			if (hit_wday && ctl_reg.unlock)
				ret_next.setpoint.wday = {4'h0, pwdata[3:0]};
			if (hit_en)
				ctl_next.match_en = pwdata[3:0];
			if (hit_ctrl) begin
				ctl_next.int_en    = pwdata[RTCA_CTRL_INT_EN];
				ret_next.bcd       = pwdata[RTCA_CTRL_BCD];
				ret_next.clk_sel   = pwdata[RTCA_CTRL_CLK_SEL];
				ret_next.mains_frequency_select  = pwdata[RTCA_CTRL_MAINS_FREQUENCY_SELECT];
				ctl_next.unlock    = pwdata[RTCA_CTRL_UNLOCK];
			end
		end

		// A new alarm in the cycle of a clearing read wins over the clear
		if (alarm_set)
			ctl_next.alarm = 1'b1;
		else if (rd_ctrl)
			ctl_next.alarm = 1'b0;

		ctl_next.wake_pulse = alarm_set & sleep_active;
		if (alarm_set && sleep_active)
			ret_next.wake_cause = 1'b1;
		else if (rd_ctrl)
			ret_next.wake_cause = 1'b0;
	end

	// Set-points, mode bits and wake cause are left alone by reset
	always_ff @(posedge pclk) begin
		ret_reg <= ret_next;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_reg.match_en   <= RTCA_EN_RESET;
			ctl_reg.int_en     <= RTCA_INT_EN_RESET;
			ctl_reg.unlock     <= RTCA_UNLOCK_RESET;
			ctl_reg.alarm      <= RTCA_ALARM_RESET;
			ctl_reg.div        <= RTCA_DIV_RESET;
			ctl_reg.xtal_sync  <= 3'h0;
			ctl_reg.mains_sync <= 3'h0;
			ctl_reg.tick       <= 1'b0;
			ctl_reg.wake_pulse <= 1'b0;
			ctl_reg.rdata      <= RTCA_RDATA_RESET;
		end else begin
			ctl_reg <= ctl_next;
		end
	end

	assign prdata             = ctl_reg.rdata;
	assign pready             = 1'b1;
	assign pslverr            = access_phase & ~mapped;
	assign osc_enable         = ~ret_reg.clk_sel;
	assign count_tick         = ctl_reg.tick;
	assign count_write_enable = ctl_reg.unlock;
	assign bcd_mode           = ret_reg.bcd;
	assign alarm_irq          = ctl_reg.alarm & ctl_reg.int_en;
	assign wake_request       = ctl_reg.wake_pulse;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_wday_write_lock: assert property (
		(bus_wr && hit_wday && !ctl_reg.unlock) |=> $stable(ret_reg.setpoint.wday))
		else $error("weekday set-point changed while locked");

	a_wday_upper_zero: assert property (
		(setup_phase && !pwrite && hit_wday) |=> (prdata[31:4] == 28'h0000000))
		else $error("weekday read shows reserved bits");

	a_en_upper_zero: assert property (
		(setup_phase && !pwrite && hit_en) |=> (prdata[31:4] == 28'h0000000))
		else $error("enable read shows reserved bits");

	a_hour_write_back: assert property (
		(bus_wr && hit_hour) |=> (ret_reg.setpoint.hour == $past(pwdata[7:0])))
		else $error("hour set-point not stored");

	a_read_clears_flag: assert property (
		(rd_ctrl && !alarm_set) |=> (!ctl_reg.alarm && !alarm_irq))
		else $error("control read left alarm flag set");

	a_flag_only_on_eval: assert property (
		(!ctl_reg.alarm && !evaluate) |=> !ctl_reg.alarm)
		else $error("alarm flag rose without evaluation");

	a_div_restart: assert property (
		wr_ctrl |=> (ctl_reg.div == RTCA_DIV_RESET))
		else $error("control write did not clear divider");

	a_irq_follows_alarm: assert property (
		(alarm_set && ctl_reg.int_en && !wr_ctrl) |=> alarm_irq)
		else $error("enabled alarm raised no interrupt");

	a_irq_masked: assert property (
		(wr_ctrl && !pwdata[RTCA_CTRL_INT_EN]) |=> !alarm_irq)
		else $error("interrupt raised while disabled");

	a_mains_osc_off: assert property (
		(wr_ctrl && pwdata[RTCA_CTRL_CLK_SEL]) |=> !osc_enable)
		else $error("crystal left enabled on mains source");

	a_mains_tick_60: assert property (
		(count_tick && ret_reg.clk_sel && !ret_reg.mains_frequency_select) |-> $past(div_limit) == RTCA_MAINS_60_DIV)
		else $error("mains tick with wrong prescale");

	a_wake_read_clear: assert property (
		(rd_ctrl && !alarm_set) |=> !ret_reg.wake_cause)
		else $error("control read left wake cause set");

	a_no_tick_unlocked: assert property (
		(ctl_reg.unlock && $past(ctl_reg.unlock)) |-> !count_tick)
		else $error("tick while counter unlocked");

	a_status_ignore_wr: assert property (
		(wr_ctrl && !ctl_reg.alarm && !alarm_set) |=> !ctl_reg.alarm)
		else $error("write set the alarm flag");

	a_none_enabled: assert property (
		(evaluate && ctl_reg.match_en == 4'h0 && !ctl_reg.alarm) |=> !ctl_reg.alarm)
		else $error("alarm with all fields disabled");

	a_full_match: assert property (
		(evaluate && ctl_reg.match_en == 4'hf && field_eq == 4'hf) |=> ctl_reg.alarm)
		else $error("full match gave no alarm");

	a_partial_match: assert property (
		(evaluate && (|(ctl_reg.match_en & ~field_eq)) && !ctl_reg.alarm) |=> !ctl_reg.alarm)
		else $error("alarm despite a mismatching enabled field");

	a_relock_eval: assert property (
		(relock && match) |=> ctl_reg.alarm)
		else $error("relock with a match gave no alarm");

	a_sec_write_back: assert property (
		(bus_wr && hit_sec) |=> (ret_reg.setpoint.second == $past(pwdata[7:0])))
		else $error("seconds set-point not stored");

	a_min_write_back: assert property (
		(bus_wr && hit_min) |=> (ret_reg.setpoint.minute == $past(pwdata[7:0])))
		else $error("minutes set-point not stored");

	a_wday_write_open: assert property (
		(bus_wr && hit_wday && ctl_reg.unlock) |=> (ret_reg.setpoint.wday == {4'h0, $past(pwdata[3:0])}))
		else $error("weekday set-point not stored while unlocked");

	a_en_write_back: assert property (
		(bus_wr && hit_en) |=> (ctl_reg.match_en == $past(pwdata[3:0])))
		else $error("field enables not stored");

	a_en_held: assert property (
		!(bus_wr && hit_en) |=> $stable(ctl_reg.match_en))
		else $error("field enables changed without a write");

	a_en_reset_clear: assert property (
		$rose(presetn) |-> (ctl_reg.match_en == RTCA_EN_RESET && !ctl_reg.int_en && !ctl_reg.unlock))
		else $error("reset left enables or control bits set");

	a_hour_read_view: assert property (
		(setup_phase && !pwrite && hit_hour) |=> (prdata == {24'h000000, $past(ret_reg.setpoint.hour)}))
		else $error("hour read differs from set-point");

	a_ctrl_read_view: assert property (
		(setup_phase && !pwrite && hit_ctrl) |=> (!prdata[2] && prdata[31:8] == 24'h000000))
		else $error("control read shows reserved bits");

	a_int_en_write: assert property (
		wr_ctrl |=> (ctl_reg.int_en == $past(pwdata[RTCA_CTRL_INT_EN])))
		else $error("interrupt enable not stored");

	a_bcd_write: assert property (
		wr_ctrl |=> (bcd_mode == $past(pwdata[RTCA_CTRL_BCD])))
		else $error("encoding bit not stored");

	a_freq_write: assert property (
		wr_ctrl |=> (ret_reg.mains_frequency_select == $past(pwdata[RTCA_CTRL_MAINS_FREQUENCY_SELECT])))
		else $error("mains frequency bit not stored");

	a_unlock_write: assert property (
		wr_ctrl |=> (count_write_enable == $past(pwdata[RTCA_CTRL_UNLOCK])))
		else $error("unlock bit not stored");

	a_xtal_osc_on: assert property (
		(wr_ctrl && !pwdata[RTCA_CTRL_CLK_SEL]) |=> osc_enable)
		else $error("crystal not enabled on crystal source");

	a_xtal_tick_div: assert property (
		(count_tick && !ret_reg.clk_sel) |-> ($past(ctl_reg.div) == RTCA_XTAL_DIV - 16'h0001))
		else $error("crystal tick with wrong prescale");

	a_mains_tick_50: assert property (
		(count_tick && ret_reg.clk_sel && ret_reg.mains_frequency_select) |-> ($past(ctl_reg.div) == RTCA_MAINS_50_DIV - 16'h0001))
		else $error("mains tick with wrong prescale");

	a_tick_one_cycle: assert property (
		count_tick |=> !count_tick)
		else $error("tick longer than one cycle");

	a_div_held_unlocked: assert property (
		(ctl_reg.unlock && !wr_ctrl) |=> $stable(ctl_reg.div))
		else $error("divider moved while unlocked");

	a_wake_sets: assert property (
		(alarm_set && sleep_active) |=> (ret_reg.wake_cause && wake_request))
		else $error("alarm in sleep did not record wake cause");

	a_wake_only_sleep: assert property (
		(!sleep_active || !alarm_set) |=> !wake_request)
		else $error("wake request without alarm in sleep");

	a_wake_ignore_wr: assert property (
		(wr_ctrl && !ret_reg.wake_cause && !(alarm_set && sleep_active)) |=> !ret_reg.wake_cause)
		else $error("write set the wake cause");

endmodule // rtca_alarm_ctrl
`default_nettype wire

// ==== tb/rtca_source_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module rtca_source_model (
	input  wire logic pclk,
	input  wire logic osc_enable,
	output logic      xtal_in,
	output logic      mains_in
);
	logic [1:0] ph;
	initial begin
		xtal_in = 1'b0;
		mains_in = 1'b0;
		ph = 2'h0;
	end
	// Crystal toggles every clock only while enabled, so one crystal tick stays short
	always @(posedge pclk) begin
		if (osc_enable === 1'b1) begin
			xtal_in <= ~xtal_in;
		end
		ph <= ph + 2'h1;
		mains_in <= ph[1];
	end
endmodule // rtca_source_model
`default_nettype wire

// ==== tb/rtca_alarm_ctrl_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
module rtca_alarm_ctrl_bench
	import rtca_pkg::*;
;
	logic                   pclk;
	logic                   presetn;
	logic                   psel;
	logic                   penable;
	logic                   pwrite;
	logic [RTCA_ADDR_W-1:0] paddr;
	logic [31:0]            pwdata;
	logic [31:0]            prdata;
	logic                   pready;
	logic                   pslverr;
	logic                   xtal_in;
	logic                   mains_in;
	rtca_time_t             now_v;
	logic                   adv_p;
	logic                   sleep_active;
	logic                   osc_enable;
	logic                   count_tick;
	logic                   count_write_enable;
	logic                   bcd_mode;
	logic                   alarm_irq;
	logic                   wake_request;
	int                     err_count;
	int                     compares;
	int                     cyc;
	int                     k;
	logic [31:0]            r;
	logic                   e;

	rtca_alarm_ctrl uut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.xtal_in(xtal_in), .mains_in(mains_in), .count_now(now_v), .count_advanced(adv_p),
		.sleep_active(sleep_active), .osc_enable(osc_enable), .count_tick(count_tick),
		.count_write_enable(count_write_enable), .bcd_mode(bcd_mode), .alarm_irq(alarm_irq),
		.wake_request(wake_request)
	);
	rtca_source_model src (
		.pclk(pclk), .osc_enable(osc_enable), .xtal_in(xtal_in), .mains_in(mains_in)
	);

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic give_verdict();
		$display("Compares %0d, mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			err_count++;
			give_verdict();
		end
	end

	task automatic rst();
		presetn <= 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
	endtask

	// An idle cycle after each transfer keeps psel from being assigned twice in one step
	task automatic apb(input logic [9:0] idx, input logic w, input logic [7:0] d,
		output logic [31:0] rd, output logic er);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [9:0] idx, input logic [7:0] d);
		logic [31:0] v;
		logic        x;
		apb(idx, 1'b1, d, v, x);
	endtask

	task automatic rdc(input string what, input logic [9:0] idx, input logic [31:0] exp);
		logic [31:0] v;
		logic        x;
		apb(idx, 1'b0, 8'h00, v, x);
		chk(what, v, exp);
	endtask

	task automatic adv(input logic ei, input logic ew);
		adv_p <= 1'b1;
		@(posedge pclk);
		adv_p <= 1'b0;
		@(negedge pclk);
		chk("irq", alarm_irq, ei);
		chk("wake", wake_request, ew);
		@(posedge pclk);
	endtask

	// Synchroniser lag lets one edge fall either side of the count
	task automatic measure(input logic [7:0] c, input int n);
		int   ed;
		logic p;
		logic s;
		ed = 0;
		wr(RTCA_IDX_CTRL, c);
		p = c[4] ? mains_in : xtal_in;
		do begin
			@(posedge pclk);
			s = c[4] ? mains_in : xtal_in;
			ed += int'(s && !p);
			p = s;
		end while (count_tick !== 1'b1);
		chk("edges per tick", 32'((ed >= n - 1) && (ed <= n + 1)), 32'h1);
	endtask

	initial begin
		cyc = 0;
		err_count = 0;
		compares = 0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = 32'h0;
		now_v = 32'h0;
		adv_p = 1'b0;
		sleep_active = 1'b0;
		rst();
		rdc("enables", RTCA_IDX_ALARM_EN, 32'h0);
		apb(RTCA_IDX_CTRL, 1'b0, 8'h00, r, e);
		chk("ctrl reset bits", r & 32'h41, 32'h0);
		wr(RTCA_IDX_ALARM_HOUR, 8'h23);
		rdc("hour", RTCA_IDX_ALARM_HOUR, 32'h23);
		wr(RTCA_IDX_ALARM_SEC, 8'h59);
		wr(RTCA_IDX_ALARM_MIN, 8'h3b);
		rdc("second", RTCA_IDX_ALARM_SEC, 32'h59);
		rdc("minute", RTCA_IDX_ALARM_MIN, 32'h3b);
		wr(RTCA_IDX_CTRL, 8'h01);
		wr(RTCA_IDX_ALARM_WDAY, 8'hf5);
		wr(RTCA_IDX_CTRL, 8'h00);
		wr(RTCA_IDX_ALARM_WDAY, 8'h03);
		rdc("weekday", RTCA_IDX_ALARM_WDAY, 32'h05);
		wr(RTCA_IDX_ALARM_EN, 8'hff);
		rdc("enables", RTCA_IDX_ALARM_EN, 32'h0f);
		wr(RTCA_IDX_CTRL, 8'ha6);
		rdc("ctrl", RTCA_IDX_CTRL, 32'h20);
		chk("bcd", bcd_mode, 32'h1);
		rst();
		rdc("hour kept", RTCA_IDX_ALARM_HOUR, 32'h23);
		rdc("enables", RTCA_IDX_ALARM_EN, 32'h0);
		rdc("ctrl", RTCA_IDX_CTRL, 32'h20);
		now_v <= 32'h0523_0000;
		wr(RTCA_IDX_ALARM_EN, 8'h04);
		wr(RTCA_IDX_CTRL, 8'h60);
		adv(1'b1, 1'b0);
		rdc("ctrl", RTCA_IDX_CTRL, 32'he0);
		chk("irq", alarm_irq, 32'h0);
		rdc("ctrl", RTCA_IDX_CTRL, 32'h60);
		wr(RTCA_IDX_ALARM_EN, 8'h00);
		adv(1'b0, 1'b0);
		wr(RTCA_IDX_ALARM_EN, 8'h0c);
		now_v <= 32'h0423_0000;
		adv(1'b0, 1'b0);
		now_v <= 32'h0523_0000;
		adv(1'b1, 1'b0);
		wr(RTCA_IDX_CTRL, 8'h20);
		rdc("ctrl", RTCA_IDX_CTRL, 32'ha0);
		adv(1'b0, 1'b0);
		rdc("ctrl", RTCA_IDX_CTRL, 32'ha0);
		repeat (4) @(posedge pclk);
		rdc("ctrl", RTCA_IDX_CTRL, 32'h20);
		wr(RTCA_IDX_CTRL, 8'h21);
		wr(RTCA_IDX_CTRL, 8'h20);
		rdc("ctrl", RTCA_IDX_CTRL, 32'ha0);
		sleep_active <= 1'b1;
		adv(1'b0, 1'b1);
		sleep_active <= 1'b0;
		rdc("ctrl", RTCA_IDX_CTRL, 32'ha2);
		rdc("ctrl", RTCA_IDX_CTRL, 32'h20);
		wr(RTCA_IDX_ALARM_EN, 8'h03);
		now_v <= 32'h0523_3a59;
		adv(1'b0, 1'b0);
		rdc("ctrl", RTCA_IDX_CTRL, 32'h20);
		now_v <= 32'h0523_3b59;
		adv(1'b0, 1'b0);
		rdc("ctrl", RTCA_IDX_CTRL, 32'ha0);
		apb(10'h0ee, 1'b0, 8'h00, r, e);
		chk("unmapped data", r, 32'h0);
		chk("unmapped err", e, 32'h1);
		wr(RTCA_IDX_CTRL, 8'h11);
		k = 0;
		repeat (300) begin
			@(posedge pclk);
			k += int'(count_tick === 1'b1);
		end
		chk("ticks unlocked", k, 32'h0);
		chk("write enable", count_write_enable, 32'h1);
		wr(RTCA_IDX_CTRL, 8'h10);
		repeat (100) @(posedge pclk);
		measure(8'h10, 60);
		measure(8'h18, 50);
		chk("osc", osc_enable, 32'h0);
		measure(8'h00, 32768);
		chk("osc", osc_enable, 32'h1);
		give_verdict();
	end
endmodule // rtca_alarm_ctrl_bench
`default_nettype wire
